// ==== rtl/msm_pkg.sv ====
// package for the memory seat motor controller: timing, register map, carriers
// assumes a 50 MHz system clock; every time below the clock and tick setup is counted in 1 ms ticks
package msm_pkg;

	// clock and the 1 ms tick derived from it
	localparam int CLK_NS      = 20;
	localparam int TICK_NS     = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;

	// axes, in start priority order
	localparam int NAX     = 4;
	localparam int AX_SLD  = 0;
	localparam int AX_REC  = 1;
	localparam int AX_FRH  = 2;
	localparam int AX_RRH  = 3;

	// times in ms
	localparam logic [15:0] T_SAME_MS    = 16'h0032; // 50: presses closer than this are void
	localparam logic [15:0] T_REV_SLD_MS = 16'h003C; // 60: slide reverse pause
	localparam logic [15:0] T_REV_OTH_MS = 16'h0064; // 100: recline/height reverse pause
	localparam logic [15:0] T_GAP_MS     = 16'h0064; // 100: spacing of motor starts
	localparam logic [15:0] T_PWIN_MS    = 16'h03E8; // 1000: pulse sensor check window
	localparam logic [15:0] T_RWIN_MS    = 16'h0DAC; // 3500: recline sensor check window
	localparam logic [15:0] T_SPEED_MS   = 16'h09C4; // 2500: speed must persist this long
	localparam logic [15:0] T_RUN_SLD_MS = 16'h4E20; // 20000
	localparam logic [15:0] T_RUN_REC_MS = 16'h88B8; // 35000
	localparam logic [15:0] T_RUN_HGT_MS = 16'h2710; // 10000
	localparam logic [15:0] T_BEEP_MS    = 16'h0064; // 100: beep on, then as long off

	// thresholds
	localparam logic [7:0]  SPEED_LIMIT  = 8'h03;    // km/h
	localparam logic [3:0]  MIN_SLD_PULS = 4'h6;
	localparam logic [3:0]  MIN_HGT_PULS = 4'h4;
	localparam logic [11:0] MIN_REC_MV   = 12'h032;  // 50 mV
	localparam logic [15:0] REC_TOL_MV   = 16'h0004; // replay stop band on the analog axis

	// beep counts
	localparam logic [3:0]  BEEP_PERMIT  = 4'h1;
	localparam logic [3:0]  BEEP_STORE   = 4'h2;
	localparam logic [3:0]  BEEP_REPLAY  = 4'h1;
	localparam logic [3:0]  BEEP_FAULT   = 4'hA;

	// register map (byte addresses)
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_POS_A    = 8'h08;
	localparam logic [7:0]  OFS_POS_B    = 8'h0C;
	localparam logic [1:0]  CTRL_RST     = 2'h1;     // memory enabled, no software stop
	localparam int          CTRL_MEM_EN  = 0;
	localparam int          CTRL_STOP    = 1;

	// motor direction codes {rev, fwd}
	localparam logic [1:0]  DIR_OFF      = 2'h0;
	localparam logic [1:0]  DIR_FWD      = 2'h1;
	localparam logic [1:0]  DIR_REV      = 2'h2;

	typedef enum logic [1:0] {
		CMD_NONE     = 2'b00,
		CMD_PERMIT   = 2'b01,
		CMD_POSITION = 2'b10
	} msm_cmd_e;

	typedef enum logic [1:0] {
		PR_IDLE = 2'b00,
		PR_WAIT = 2'b01,
		PR_VOID = 2'b10
	} msm_press_e;

	// one message from the door module, valid for one cycle
	typedef struct packed {
		logic     valid;
		logic     src_ok;
		msm_cmd_e cmd;
		logic     slot;
	} msm_can_s;

	// manual seat switches, bit index = axis
	typedef struct packed {
		logic [3:0] fwd;
		logic [3:0] rev;
	} msm_sw_s;

endpackage : msm_pkg

// ==== rtl/msm_seat_ctrl.sv ====
// memory seat motor controller: manual drive, two-slot memory, replay, buzzer, faults
// assumes all pins synchronous to clk; reset stands for loss of battery power
//
// Function
// R01: run slide, recline, front and rear height motors from manual switches.
// R02: manual switches may drive all four axes at the same time.
// R03: manual slide and recline work even without door module messages.
// R04: registration commands accepted only from the door module message source.
// R05: memory-permit cancelled on ignition off or any manual switch.
// R06: two position presses within 50 ms void both; otherwise first counts.
// R07: no registration above 3 km/h or outside park; keyless lock stores without either check.
// R08: two stored positions, each overwritable without limit.
// R09: keyless lock stores positions, keyless unlock replays them, per person.
// R10: stored positions are lost on power removal.
// R11: ignition on, position press replays its slot; empty slots never replay.
// R12: latest press wins during replay; two presses within 50 ms replay nothing.
// R13: ignition, park, sustained speed, manual switch or stop switch abort replay.
// R14: beeps: once permit, twice stored, once replay, ten times fault.
// R15: under 6 slide or 4 height pulses in 1 s flags fault.
// R16: recline change under 50 mV in 3.5 s flags fault.
// R17: fault stops replay but keeps manual drive.
// R18: good sensor movement under manual drive clears fault, allowing replay.
// R19: reversal waits 60 ms for slide, 100 ms for others.
// R20: motor starts spaced 100 ms, slide, recline, front, rear priority.
// R21: run timers 20 s slide, 35 s recline in replay, 10 s height.
// R22: manual slide and recline run only while the switch is held.
// R23: pulse counters track position and stop replay at the target.
`timescale 1ns/100ps
`default_nettype none

module msm_seat_ctrl #(
	parameter int TICK_CYCLES = msm_pkg::TICK_CYCLES
) (
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire msm_pkg::msm_sw_s  man_sw,
	input  wire msm_pkg::msm_can_s can_in,
	input  wire logic            ign_on,
	input  wire logic            park_sw,
	input  wire logic [7:0]      speed_kmh,
	input  wire logic            stop_sw,
	input  wire logic            key_lock,
	input  wire logic            key_unlock,
	input  wire logic            key_slot,
	input  wire logic            pulse_slide,
	input  wire logic            pulse_front,
	input  wire logic            pulse_rear,
	input  wire logic [11:0]     recline_mv,
	output logic      [3:0]      motor_fwd,
	output logic      [3:0]      motor_rev,
	output logic                 buzzer
);
	import msm_pkg::*;

	// helpers used by several axes
	function automatic logic [1:0] toward(input logic [15:0] cur, input logic [15:0] tgt,
		input logic [15:0] tol);
		logic [16:0] c;
		logic [16:0] t;
		c = {1'b0, cur};
		t = {1'b0, tgt};
		if (c + {1'b0, tol} < t) toward = DIR_FWD;
		else if (c > t + {1'b0, tol}) toward = DIR_REV;
		else toward = DIR_OFF;
	endfunction : toward

	function automatic logic [15:0] rev_pause(input int a);
		rev_pause = (a == AX_SLD) ? T_REV_SLD_MS : T_REV_OTH_MS;
	endfunction : rev_pause

	function automatic logic [15:0] run_limit(input int a);
		if (a == AX_SLD) run_limit = T_RUN_SLD_MS;
		else if (a == AX_REC) run_limit = T_RUN_REC_MS;
		else run_limit = T_RUN_HGT_MS;
	endfunction : run_limit

	logic [15:0]     tick_cnt_reg;
	logic            tick_reg;
	logic [3:0]      pulse_d_reg;
	logic [3:0]      pulse_in;
	logic [3:0]      pulse_rise;
	logic [15:0]     pos_cnt_reg [NAX];
	logic [15:0]     pos [NAX];
	logic [15:0]     mem_reg [2][NAX];
	logic [1:0]      mem_valid_reg;
	logic [1:0]      man_dir [NAX];
	logic [1:0]      want [NAX];
	logic [1:0]      last_dir_reg [NAX];
	logic [15:0]     dead_reg [NAX];
	logic [15:0]     run_reg [NAX];
	logic [15:0]     win_reg [NAX];
	logic [3:0]      puls_reg [NAX];
	logic [11:0]     mv0_reg;
	logic [3:0]      done_reg;
	logic [3:0]      fault_reg;
	logic [3:0]      fault_set;
	logic [3:0]      fault_ok;
	logic [3:0]      grant;
	logic            found;
	logic [15:0]     gap_reg;
	logic            manual_any;
	logic            accepted;
	msm_press_e      pr_state_reg;
	logic [15:0]     pr_cnt_reg;
	logic            pr_slot_reg;
	logic            pr_fire_reg;
	logic            permit_reg;
	logic            replay_reg;
	logic            slot_reg;
	logic [15:0]     spd_cnt_reg;
	logic            speed_long;
	logic            replay_ok;
	logic            replay_req;
	logic            replay_slot;
	logic            replay_start;
	logic            store_now;
	logic            motors_idle;
	logic [3:0]      beeps_reg;
	logic [15:0]     beat_reg;
	logic [1:0]      ctrl_reg;
	logic [31:0]     rd_data;
	logic            rd_err;

	// 1 ms tick so all timers stay 16 bits wide
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			tick_reg     <= 1'b0;
		end
	end

	// sensor pulse edges; recline has a potentiometer, not pulses
	assign pulse_in   = {pulse_rear, pulse_front, 1'b0, pulse_slide};
	assign pulse_rise = pulse_in & ~pulse_d_reg;
	assign manual_any = |(man_sw.fwd | man_sw.rev);
	assign accepted   = can_in.valid & can_in.src_ok & ctrl_reg[CTRL_MEM_EN]; // R04
	assign motors_idle = ~|(motor_fwd | motor_rev);

	// position tracking: counters for pulse axes, analog level for recline
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pulse_d_reg <= 4'h0;
			for (int a = 0; a < NAX; a++) pos_cnt_reg[a] <= 16'h0000;
		end else begin
			pulse_d_reg <= pulse_in;
			for (int a = 0; a < NAX; a++) begin
				if (pulse_rise[a] && last_dir_reg[a] == DIR_FWD)
					pos_cnt_reg[a] <= pos_cnt_reg[a] + 16'h0001; // R23
				else if (pulse_rise[a] && last_dir_reg[a] == DIR_REV)
					pos_cnt_reg[a] <= pos_cnt_reg[a] - 16'h0001; // R23
			end
		end
	end

	always_comb begin
		for (int a = 0; a < NAX; a++) pos[a] = pos_cnt_reg[a];
		pos[AX_REC] = {4'h0, recline_mv};
	end

	// wanted direction: manual switch first, then replay toward the slot
	always_comb begin
		for (int a = 0; a < NAX; a++) begin
			man_dir[a] = {man_sw.rev[a] & ~man_sw.fwd[a], man_sw.fwd[a] & ~man_sw.rev[a]};
			if (man_dir[a] != DIR_OFF)
				want[a] = done_reg[a] ? DIR_OFF : man_dir[a]; // R01 R02 R03 R22
			else if (replay_reg && !done_reg[a])
				want[a] = toward(pos[a], mem_reg[slot_reg][a],
					(a == AX_REC) ? REC_TOL_MV : 16'h0000); // R23
			else
				want[a] = DIR_OFF;
		end
	end

	// one start per gap, lowest axis index first
	always_comb begin
		found = 1'b0;
		grant = 4'h0;
		for (int a = 0; a < NAX; a++) begin
			if (!found && gap_reg == 16'h0000 && dead_reg[a] == 16'h0000 &&
				{motor_rev[a], motor_fwd[a]} == DIR_OFF && want[a] != DIR_OFF) begin
				grant[a] = 1'b1; // R20
				found    = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			gap_reg <= 16'h0000;
		else if (|grant)
			gap_reg <= T_GAP_MS; // R20
		else if (tick_reg && gap_reg != 16'h0000)
			gap_reg <= gap_reg - 16'h0001;
	end

	// per-axis drive, reverse pause, run timer and sensor check
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			motor_fwd <= 4'h0;
			motor_rev <= 4'h0;
			done_reg  <= 4'h0;
			mv0_reg   <= 12'h000;
			for (int a = 0; a < NAX; a++) begin
				last_dir_reg[a] <= DIR_OFF;
				dead_reg[a]     <= 16'h0000;
				run_reg[a]      <= 16'h0000;
				win_reg[a]      <= 16'h0000;
				puls_reg[a]     <= 4'h0;
			end
		end else begin
			for (int a = 0; a < NAX; a++) begin
				if (grant[a]) begin
					{motor_rev[a], motor_fwd[a]} <= want[a];
					last_dir_reg[a] <= want[a];
					run_reg[a]      <= 16'h0000;
					win_reg[a]      <= (a == AX_REC) ? T_RWIN_MS : T_PWIN_MS;
					puls_reg[a]     <= 4'h0;
					if (a == AX_REC) mv0_reg <= recline_mv;
				end else if ({motor_rev[a], motor_fwd[a]} != DIR_OFF) begin
					if (want[a] != {motor_rev[a], motor_fwd[a]}) begin
						{motor_rev[a], motor_fwd[a]} <= DIR_OFF;
						dead_reg[a] <= rev_pause(a); // R19
					end else if (tick_reg) begin
						run_reg[a] <= run_reg[a] + 16'h0001;
						if (win_reg[a] != 16'h0000) win_reg[a] <= win_reg[a] - 16'h0001;
					end
					if (pulse_rise[a] && puls_reg[a] != 4'hF) puls_reg[a] <= puls_reg[a] + 4'h1;
				end else if (tick_reg && dead_reg[a] != 16'h0000) begin
					dead_reg[a] <= dead_reg[a] - 16'h0001; // R19
				end
				// timer expiry parks the axis until a replay starts, or its switch is let go with no replay running
				if (replay_start)
					done_reg[a] <= 1'b0;
				else if ({motor_rev[a], motor_fwd[a]} != DIR_OFF && run_reg[a] >= run_limit(a) &&
					(replay_reg || a >= AX_FRH))
					done_reg[a] <= 1'b1; // R21
				else if (!replay_reg && man_dir[a] == DIR_OFF)
					done_reg[a] <= 1'b0;
			end
		end
	end

	// sensor verdict at the end of each check window
	always_comb begin
		for (int a = 0; a < NAX; a++) begin
			fault_set[a] = 1'b0;
			fault_ok[a]  = 1'b0;
			if (tick_reg && win_reg[a] == 16'h0001 && {motor_rev[a], motor_fwd[a]} != DIR_OFF &&
				want[a] == {motor_rev[a], motor_fwd[a]}) begin
				if (a == AX_REC) begin
					fault_set[a] = ((recline_mv > mv0_reg) ? recline_mv - mv0_reg :
						mv0_reg - recline_mv) < MIN_REC_MV; // R16
				end else begin
					fault_set[a] = puls_reg[a] < ((a == AX_SLD) ? MIN_SLD_PULS : MIN_HGT_PULS); // R15
				end
				fault_ok[a] = ~fault_set[a] & ~replay_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			fault_reg <= 4'h0;
		else
			fault_reg <= fault_set | (fault_reg & ~fault_ok); // R15 R16 R18
	end

	// sustained overspeed for replay abort
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			spd_cnt_reg <= 16'h0000;
		else if (speed_kmh <= SPEED_LIMIT)
			spd_cnt_reg <= 16'h0000;
		else if (tick_reg && spd_cnt_reg != T_SPEED_MS)
			spd_cnt_reg <= spd_cnt_reg + 16'h0001; // R13
	end
	assign speed_long = (spd_cnt_reg == T_SPEED_MS);

	// position press arbitration: a second press inside the window voids both
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pr_state_reg <= PR_IDLE;
			pr_cnt_reg   <= 16'h0000;
			pr_slot_reg  <= 1'b0;
			pr_fire_reg  <= 1'b0;
		end else begin
			pr_fire_reg <= 1'b0;
			case (pr_state_reg)
				PR_IDLE: begin
					if (accepted && can_in.cmd == CMD_POSITION) begin
						pr_state_reg <= PR_WAIT;
						pr_slot_reg  <= can_in.slot;
						pr_cnt_reg   <= 16'h0000;
					end
				end
				PR_WAIT: begin
					if (accepted && can_in.cmd == CMD_POSITION) begin
						pr_state_reg <= PR_VOID; // R06 R12
					end else if (tick_reg && pr_cnt_reg == T_SAME_MS - 16'h0001) begin
						pr_state_reg <= PR_IDLE;
						pr_fire_reg  <= 1'b1; // R06
					end else if (tick_reg) begin
						pr_cnt_reg <= pr_cnt_reg + 16'h0001;
					end
				end
				PR_VOID: begin
					if (tick_reg && pr_cnt_reg >= T_SAME_MS - 16'h0001)
						pr_state_reg <= PR_IDLE;
					else if (tick_reg)
						pr_cnt_reg <= pr_cnt_reg + 16'h0001;
				end
				default: pr_state_reg <= PR_IDLE;
			endcase
		end
	end

	// replay conditions and triggers
	assign replay_ok = ign_on & park_sw & ~speed_long & ~manual_any & ~stop_sw &
		~ctrl_reg[CTRL_STOP] & ~|fault_reg; // R13 R17
	assign replay_req  = (pr_fire_reg & ~permit_reg) | key_unlock; // R09 R11
	assign replay_slot = key_unlock ? key_slot : pr_slot_reg;
	assign replay_start = replay_req & replay_ok & mem_valid_reg[replay_slot]; // R11
	assign store_now = pr_fire_reg & permit_reg & (speed_kmh <= SPEED_LIMIT) & park_sw; // R07

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			replay_reg <= 1'b0;
			slot_reg   <= 1'b0;
		end else if (replay_start) begin
			replay_reg <= 1'b1; // R12
			slot_reg   <= replay_slot;
		end else if (!replay_ok) begin
			replay_reg <= 1'b0; // R13 R17
		end else if (replay_reg && motors_idle && {want[0], want[1], want[2], want[3]} == 8'h00) begin
			replay_reg <= 1'b0; // R23
		end
	end

	// memory-permit state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			permit_reg <= 1'b0;
		else if (!ign_on || manual_any || store_now)
			permit_reg <= 1'b0; // R05
		else if (accepted && can_in.cmd == CMD_PERMIT)
			permit_reg <= 1'b1; // R04
	end

	// two volatile slots; cleared only by reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem_valid_reg <= 2'h0; // R10
			for (int s = 0; s < 2; s++)
				for (int a = 0; a < NAX; a++) mem_reg[s][a] <= 16'h0000;
		end else if (store_now || key_lock) begin
			mem_valid_reg[key_lock ? key_slot : pr_slot_reg] <= 1'b1; // R08 R09
			for (int a = 0; a < NAX; a++)
				mem_reg[key_lock ? key_slot : pr_slot_reg][a] <= pos[a];
		end
	end

	// buzzer: beats of 100 ms on, 100 ms off; a new request restarts it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			beeps_reg <= 4'h0;
			beat_reg  <= 16'h0000;
			buzzer    <= 1'b0;
		end else begin
			if (|fault_set && fault_set != (fault_set & fault_reg)) begin
				beeps_reg <= BEEP_FAULT; // R14
				beat_reg  <= 16'h0000;
			end else if (store_now) begin
				beeps_reg <= BEEP_STORE; // R14
				beat_reg  <= 16'h0000;
			end else if (replay_start) begin
				beeps_reg <= BEEP_REPLAY; // R14
				beat_reg  <= 16'h0000;
			end else if (accepted && can_in.cmd == CMD_PERMIT && ign_on && !permit_reg) begin
				beeps_reg <= BEEP_PERMIT; // R14
				beat_reg  <= 16'h0000;
			end else if (tick_reg && beeps_reg != 4'h0) begin
				if (beat_reg == (T_BEEP_MS << 1) - 16'h0001) begin
					beat_reg  <= 16'h0000;
					beeps_reg <= beeps_reg - 4'h1;
				end else begin
					beat_reg <= beat_reg + 16'h0001;
				end
			end
			buzzer <= (beeps_reg != 4'h0) && (beat_reg < T_BEEP_MS);
		end
	end

	// apb read mux; unmapped addresses answer with an error
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (paddr == OFS_CTRL)
			rd_data = {30'h0000_0000, ctrl_reg};
		else if (paddr == OFS_STATUS)
			rd_data = {12'h000, motor_rev, motor_fwd, 1'b0, speed_long, mem_valid_reg,
				fault_reg, 1'b0, slot_reg, replay_reg, permit_reg};
		else if (paddr == OFS_POS_A)
			rd_data = {pos[AX_REC], pos[AX_SLD]};
		else if (paddr == OFS_POS_B)
			rd_data = {pos[AX_RRH], pos[AX_FRH]};
		else
			rd_err = 1'b1;
	end

	// one wait state keeps pready and prdata straight from flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
			pslverr <= psel & penable & ~pready & rd_err;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ctrl_reg <= CTRL_RST;
		else if (psel && penable && pready && pwrite && paddr == OFS_CTRL)
			ctrl_reg <= pwdata[1:0];
	end

endmodule : msm_seat_ctrl

`default_nettype wire

// ==== dv/msm_seat_asserts.sv ====
// checker for msm_seat_ctrl: start spacing, reverse pauses, run timer, aborts, bus wait
// bound to the controller; TICK_CYCLES is handed on from the instance it watches
`timescale 1ns/100ps
`default_nettype none
module msm_seat_asserts
	import msm_pkg::*;
#(
	parameter int TICK_CYCLES = 50
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire msm_pkg::msm_sw_s  man_sw,
	input wire logic              ign_on,
	input wire logic              park_sw,
	input wire logic              stop_sw,
	input wire logic [3:0]        motor_fwd,
	input wire logic [3:0]        motor_rev
);
	// one tick of slack, the timebase phase is unknown at each start
	localparam int GAP  = 99 * TICK_CYCLES - 1;
	localparam int SREV = 59 * TICK_CYCLES - 1;
	localparam int HRUN = 10001 * TICK_CYCLES;
	logic [7:0]  mot_reg;
	logic [7:0]  rise;
	logic [31:0] gap_reg;
	logic [31:0] sidl_reg;
	logic [31:0] ridl_reg;
	logic [31:0] hrun_reg;
	logic        quiet;
	assign rise  = {motor_rev, motor_fwd} & ~mot_reg;
	assign quiet = {motor_rev, motor_fwd} == 8'h00;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// counters start saturated so the first start after reset is legal
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mot_reg  <= 8'h00;
			gap_reg  <= '1;
			sidl_reg <= '1;
			ridl_reg <= '1;
		end else begin
			mot_reg  <= {motor_rev, motor_fwd};
			gap_reg  <= (rise != 8'h00) ? 32'h0 : gap_reg + {31'h0, ~&gap_reg};
			sidl_reg <= (motor_fwd[0] | motor_rev[0]) ? 32'h0 : sidl_reg + {31'h0, ~&sidl_reg};
			ridl_reg <= (motor_fwd[1] | motor_rev[1]) ? 32'h0 : ridl_reg + {31'h0, ~&ridl_reg};
		end
	end
	// front height run length, for its run timer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hrun_reg <= 32'h0;
		else
			hrun_reg <= (motor_fwd[2] | motor_rev[2]) ? hrun_reg + 32'h1 : 32'h0;
	end
	AST_DIR_EXCL: assert property ((motor_fwd & motor_rev) == 4'h0)
		else $error("motor driven both ways");
	AST_START_GAP: assert property (rise != 8'h00 |-> $onehot(rise) && gap_reg >= GAP)
		else $error("motor starts not spaced");
	AST_SLD_REV: assert property (rise[0] | rise[4] |-> sidl_reg >= SREV)
		else $error("slide restarted too soon");
	AST_REC_REV: assert property (rise[1] | rise[5] |-> ridl_reg >= GAP)
		else $error("recline restarted too soon");
	AST_IGN_OFF: assert property ((!ign_on && man_sw == '0) [*4] |-> quiet)
		else $error("motor runs with ignition off");
	AST_PARK_OFF: assert property ((!park_sw && man_sw == '0) [*4] |-> quiet)
		else $error("motor runs out of park");
	AST_STOP_SW: assert property (stop_sw && man_sw == '0 ##1 $past(stop_sw, 2) && stop_sw
		&& man_sw == '0 ##2 stop_sw && man_sw == '0 |-> quiet)
		else $error("motor runs with stop switch");
	AST_HGT_RUN: assert property (hrun_reg <= HRUN)
		else $error("front height run too long");
	AST_APB_WAIT: assert property ($rose(psel && penable) |-> !pready ##1 pready)
		else $error("bus answer not after one wait");
	AST_ERR_PAIR: assert property (pslverr |-> pready && $past(psel && penable))
		else $error("error without bus answer");
	COV_ALL4: cover property (motor_fwd == 4'hF);
	COV_ABORT: cover property (stop_sw && !quiet ##4 quiet);
	COV_BUS_ERR: cover property (pslverr);
endmodule : msm_seat_asserts
bind msm_seat_ctrl msm_seat_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_msm_seat_asserts (
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .man_sw(man_sw), .ign_on(ign_on), .park_sw(park_sw),
	.stop_sw(stop_sw), .motor_fwd(motor_fwd), .motor_rev(motor_rev));
`default_nettype wire

// ==== dv/msm_door.sv ====
// door module model: sends permit and position messages, one clock each
// assumes the controller samples can_o on the rising edge of clk
`timescale 1ns/100ps
`default_nettype none
module msm_door (
	input  wire logic              clk,
	output var  msm_pkg::msm_can_s can_o
);
	import msm_pkg::*;
	initial can_o = '0;
	// between messages the fields flip, so only valid may qualify them
	task automatic send(input msm_cmd_e cmd, input logic slot, input logic src);
		@(posedge clk);
		can_o <= '{valid: 1'b1, src_ok: src, cmd: cmd, slot: slot};
		@(posedge clk);
		can_o <= '{valid: 1'b0, src_ok: ~src, cmd: msm_cmd_e'(~cmd), slot: ~slot};
	endtask : send
endmodule : msm_door
`default_nettype wire

// ==== dv/msm_tb.sv ====
// bench for msm_seat_ctrl: registers, manual drive, memory store and replay, aborts
// assumes the door model for messages; sensor pulses are made here from the motors
`timescale 1ns/100ps
`default_nettype none
module tb;
	import msm_pkg::*;
	localparam int T = 50; // clocks per ms tick, shortened for simulation
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, serr, bz_q;
	logic        ign_on, park_sw, stop_sw, key_lock, key_unlock, key_slot, buzzer;
	logic        pulse_slide, pulse_front, pulse_rear;
	logic [7:0]  paddr, speed_kmh, pdiv;
	logic [11:0] mv = 12'h200;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  motor_fwd, motor_rev;
	msm_sw_s     man_sw;
	msm_can_s    can_in;
	int          n_errors = 0, tests_run = 0, beeps = 0, b0;
	msm_seat_ctrl #(.TICK_CYCLES(T)) i_msm_seat_ctrl (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .man_sw(man_sw), .can_in(can_in), .ign_on(ign_on),
		.park_sw(park_sw), .speed_kmh(speed_kmh), .stop_sw(stop_sw), .key_lock(key_lock),
		.key_unlock(key_unlock), .key_slot(key_slot), .pulse_slide(pulse_slide),
		.pulse_front(pulse_front), .pulse_rear(pulse_rear), .recline_mv(mv),
		.motor_fwd(motor_fwd), .motor_rev(motor_rev), .buzzer(buzzer));
	msm_door i_msm_door (.clk(clk), .can_o(can_in));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// pulse sensors square up and the recline level ramps while an axis turns, well above the fault minimum
	always @(posedge clk) begin
		pdiv <= pdiv + 8'h01;
		pulse_slide <= (motor_fwd[0] | motor_rev[0]) & pdiv[7];
		pulse_front <= (motor_fwd[2] | motor_rev[2]) & pdiv[7];
		pulse_rear <= (motor_fwd[3] | motor_rev[3]) & pdiv[7];
		if (pdiv == 8'h00) mv <= mv + {11'h0, motor_fwd[1]} - {11'h0, motor_rev[1]};
		bz_q <= buzzer;
		if (buzzer && !bz_q)
			beeps <= beeps + 1;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic ms(input int n);
		repeat (n * T) @(posedge clk);
	endtask : ms
	// one bus transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (!pready);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic st();
		apb(1'b0, OFS_STATUS, 32'h0);
	endtask : st
	task automatic t_regs();
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h1);
		st();
		chk(32'(rd[9:0]), 32'h0);
		apb(1'b1, OFS_CTRL, 32'hFFFFFFFF);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk({rd[30:0], serr}, 32'h1);
	endtask : t_regs
	task automatic t_manual();
		man_sw.fwd <= 4'hF;
		ms(150);
		chk(32'(motor_fwd), 32'h3);
		ms(200);
		chk(32'(motor_fwd), 32'hF);
		man_sw.fwd <= 4'h0;
		ms(1);
		chk(32'({motor_fwd, motor_rev}), 32'h0);
		ms(120);
		i_msm_door.send(CMD_PERMIT, 1'b0, 1'b0);
		ms(5);
		st();
		chk(32'(rd[0]), 32'h0);
	endtask : t_manual
	task automatic t_store();
		b0 = beeps;
		i_msm_door.send(CMD_PERMIT, 1'b0, 1'b1);
		ms(20);
		st();
		chk(32'(rd[0]), 32'h1);
		i_msm_door.send(CMD_POSITION, 1'b0, 1'b1);
		ms(10);
		i_msm_door.send(CMD_POSITION, 1'b1, 1'b1);
		ms(70);
		st();
		chk(32'(rd[9:8]), 32'h0);
		speed_kmh <= 8'h04;
		i_msm_door.send(CMD_POSITION, 1'b1, 1'b1);
		ms(70);
		st();
		chk(32'({rd[9:8], rd[0]}), 32'h1);
		chk(32'(beeps - b0), 32'h1);
		speed_kmh <= 8'h00;
		b0 = beeps;
		i_msm_door.send(CMD_POSITION, 1'b0, 1'b1);
		ms(260);
		st();
		chk(32'({rd[9:8], rd[0]}), 32'h2);
		chk(32'(beeps - b0), 32'h2);
		i_msm_door.send(CMD_PERMIT, 1'b0, 1'b1);
		ms(20);
		man_sw.rev[3] <= 1'b1;
		ms(2);
		man_sw.rev[3] <= 1'b0;
		st();
		chk(32'(rd[0]), 32'h0);
	endtask : t_store
	task automatic t_replay();
		i_msm_door.send(CMD_POSITION, 1'b1, 1'b1);
		ms(60);
		st();
		chk(32'(rd[1]), 32'h0);
		man_sw.fwd[0] <= 1'b1;
		ms(200);
		man_sw.fwd[0] <= 1'b0;
		ms(70);
		i_msm_door.send(CMD_POSITION, 1'b0, 1'b1);
		ms(52);
		st();
		chk(32'(rd[1]), 32'h1);
		ms(70);
		chk(32'(motor_fwd[0] | motor_rev[0]), 32'h1);
		stop_sw <= 1'b1;
		ms(1);
		st();
		chk(32'({rd[1], motor_fwd, motor_rev}), 32'h0);
		stop_sw <= 1'b0;
		key_slot <= 1'b1;
		key_lock <= 1'b1;
		@(posedge clk);
		key_lock <= 1'b0;
		st();
		chk(32'(rd[9:8]), 32'h3);
		key_slot <= 1'b0;
		key_unlock <= 1'b1;
		@(posedge clk);
		key_unlock <= 1'b0;
		st();
		chk(32'(rd[1]), 32'h1);
		ign_on <= 1'b0;
		ms(1);
		st();
		chk(32'({rd[1], motor_fwd, motor_rev}), 32'h0);
		ign_on <= 1'b1;
		park_sw <= 1'b0;
		ms(1);
		key_unlock <= 1'b1;
		@(posedge clk);
		key_unlock <= 1'b0;
		st();
		chk(32'(rd[1]), 32'h0);
		park_sw <= 1'b1;
	endtask : t_replay
	task automatic complete_run();
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, stop_sw, key_lock, key_unlock, key_slot, bz_q} = '0;
		{paddr, pwdata, speed_kmh, pdiv, pulse_slide, pulse_front, pulse_rear} = '0;
		{ign_on, park_sw} = 2'b11;
		man_sw = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_manual();
		t_store();
		t_replay();
		complete_run();
	end
	// watchdog, well beyond the length of the whole sequence
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		complete_run();
	end
endmodule : tb
`default_nettype wire
